// ### rtl/tmr16_pkg.sv
package tmr16_pkg;

  // ------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [5:0] TMR16_CTRL_ADDR = 6'h00;
  localparam logic [5:0] TMR16_WAVE_ADDR = 6'h04;
  localparam logic [5:0] TMR16_DIR_ADDR = 6'h08;
  localparam logic [5:0] TMR16_BUFST_ADDR = 6'h0c;
  localparam logic [5:0] TMR16_COUNT_ADDR = 6'h10;
  localparam logic [5:0] TMR16_PERIOD_ADDR = 6'h14;
  localparam logic [5:0] TMR16_PERIOD_BUFFER_ADDR = 6'h18;
  localparam logic [5:0] TMR16_CMP_ADDR = 6'h1c;
  localparam logic [5:0] TMR16_CMPBUF_ADDR = 6'h28;
  localparam logic [5:0] TMR16_FLAGS_ADDR = 6'h34;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int TMR16_EN_BIT = 0;
  localparam int TMR16_DIV_LSB = 1;
  localparam int TMR16_EVT_BIT = 4;
  localparam int TMR16_LOCK_BIT = 5;
  localparam int TMR16_MODE_LSB = 0;
  localparam int TMR16_OE_LSB = 4;
  localparam int TMR16_NCH = 3;

  // ------------------------------------------------------------
  // Reset values and counts
  // ------------------------------------------------------------
  localparam logic [15:0] TMR16_PERIOD_RST = 16'hffff;
  localparam logic [15:0] TMR16_ZERO16 = 16'h0000;
  localparam logic [9:0] TMR16_DIV_MAX = 10'h3ff;

  typedef enum logic [1:0] {
    TMR16_NORMAL,
    TMR16_FREQ,
    TMR16_SSPWM,
    TMR16_RSVD
  } tmr16_mode_e;

endpackage

// ### rtl/tmr16_core.sv
// Operation
// - Event count enable makes events, not ticks, advance the counter.
// - Counter steps per tick, by direction in normal and reserved modes and up in frequency and single-slope modes, until peak or floor.
// - Counting up at peak, the counter returns to zero next tick.
// - Counting down at floor, the counter reloads the period value.
// - Software count write is immediate and beats any count step.
// - Direction writes accepted while running; counting follows new direction.
// - Period and compares have buffers; write sets valid, update clears it.
// - Compare and buffer both accessible; direct compare write bypasses buffer.
// - Unbuffered period write takes effect at once.
// - Period written below count while up-counting: counter wraps first.
// - Period buffer writable anytime; copied only at update point.
// - Compare equality sets channel flag on next timer tick.
// - Valid compare buffer moves to compare at update; used next count.
// - Output driven only with waveform mode and channel output enable.
// - Frequency mode: compare zero sets period; outputs toggle on match.
// - Frequency mode, compare zero 0, no prescale: toggle every clock.
// - Single-slope PWM: count floor to period; set at floor, clear on match.
// - Compare at floor gives steady low; above period gives steady high.
// - Update point at floor or peak by mode and, in normal mode, direction, unless transfer lock set.
// - Floor is count zero; peak is top of current count sequence.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module tmr16_core
  import tmr16_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [5:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic event_in,
  output logic [2:0] waveform_out_n,
  output logic [2:0] wave_drive_en
);

  typedef struct packed {
    logic enable;
    logic [2:0] clock_divider_select;
    logic event_count_enable;
    logic transfer_lock;
    logic [1:0] waveform_mode_select;
    logic [2:0] channel_output_enable;
    logic dir_down;
    logic [15:0] count;
    logic [15:0] period;
    logic [15:0] period_buffer;
    logic period_buffer_valid;
    logic [2:0][15:0] compare_n;
    logic [2:0][15:0] compare_n_buffer;
    logic [2:0] compare_buffer_valid;
    logic [2:0] match_flag;
    logic [2:0] wave;
    logic [9:0] div;
    logic [2:0] evt_sync;
    logic [31:0] rdata;
  } tmr16_state_s;

  tmr16_state_s st;
  tmr16_state_s next_st;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [9:0] div_mask(input logic [2:0] sel);
    case (sel)
      3'h0: div_mask = 10'h000;
      3'h1: div_mask = 10'h001;
      3'h2: div_mask = 10'h003;
      3'h3: div_mask = 10'h007;
      3'h4: div_mask = 10'h00f;
      3'h5: div_mask = 10'h03f;
      3'h6: div_mask = 10'h0ff;
      default: div_mask = TMR16_DIV_MAX;
    endcase
  endfunction

  function automatic logic [15:0] chan_addr(input logic [5:0] base, input int ch);
    chan_addr = {10'h000, base} + 16'(ch * 4);
  endfunction

  logic tick;
  logic [15:0] top;
  logic at_floor;
  logic at_peak;
  logic update;
  logic [2:0] match;
  tmr16_mode_e mode;

  always_comb begin
    mode = tmr16_mode_e'(st.waveform_mode_select);
    // Divider gives a one-cycle enable, never a derived clock
    if (st.event_count_enable) begin
      tick = st.enable && st.evt_sync[1] && !st.evt_sync[2];
    end else begin
      tick = st.enable && ((st.div & div_mask(st.clock_divider_select)) == 10'h000);
    end
    top = (mode == TMR16_FREQ) ? st.compare_n[0] : st.period;
    at_floor = (st.count == TMR16_ZERO16);
    at_peak = (st.count == top);
    // Single-slope and frequency update at peak, normal at floor or peak by direction
    if (mode == TMR16_NORMAL) begin
      update = tick && (st.dir_down ? at_floor : at_peak);
    end else begin
      update = tick && at_peak;
    end
    for (int i = 0; i < TMR16_NCH; i++) begin
      match[i] = (st.count == st.compare_n[i]);
    end
  end

  always_comb begin
    next_st = st;
    next_st.evt_sync = {st.evt_sync[1:0], event_in};
    next_st.div = st.enable ? st.div + 10'h001 : 10'h000;
    next_st.rdata = 32'h0000_0000;

    // ------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------
    if (tick) begin
      if (mode == TMR16_SSPWM || mode == TMR16_FREQ) begin
        next_st.count = at_peak ? TMR16_ZERO16 : st.count + 16'h0001;
      end else if (st.dir_down) begin
        next_st.count = at_floor ? st.period : st.count - 16'h0001;
      end else begin
        // Equality only: a period below count runs on to 0xffff and wraps
        next_st.count = at_peak ? TMR16_ZERO16 : st.count + 16'h0001;
      end
      for (int i = 0; i < TMR16_NCH; i++) begin
        // Flag lands on the tick after the count reached the compare value
        if (match[i]) begin
          next_st.match_flag[i] = 1'b1;
        end
        case (mode)
          TMR16_FREQ: begin
            if (match[i]) begin
              next_st.wave[i] = !st.wave[i];
            end
          end
          TMR16_SSPWM: begin
            // Clear wins at floor, so compare at floor stays low
            if (match[i]) begin
              next_st.wave[i] = 1'b0;
            end else if (at_floor) begin
              next_st.wave[i] = 1'b1;
            end
          end
          default: next_st.wave[i] = 1'b0;
        endcase
      end
    end

    // ------------------------------------------------------------
    // Update point
    // ------------------------------------------------------------
    if (update && !st.transfer_lock) begin
      if (st.period_buffer_valid) begin
        next_st.period = st.period_buffer;
        next_st.period_buffer_valid = 1'b0;
      end
      for (int i = 0; i < TMR16_NCH; i++) begin
        if (st.compare_buffer_valid[i]) begin
          next_st.compare_n[i] = st.compare_n_buffer[i];
          next_st.compare_buffer_valid[i] = 1'b0;
        end
      end
    end

    // ------------------------------------------------------------
    // Register writes, applied last so software wins, except a flag clear
    // ------------------------------------------------------------
    if (wr) begin
      case (addr)
        TMR16_CTRL_ADDR: begin
          next_st.enable = wdata[TMR16_EN_BIT];
          next_st.clock_divider_select = wdata[TMR16_DIV_LSB +: 3];
          next_st.event_count_enable = wdata[TMR16_EVT_BIT];
          next_st.transfer_lock = wdata[TMR16_LOCK_BIT];
        end
        TMR16_WAVE_ADDR: begin
          next_st.waveform_mode_select = wdata[TMR16_MODE_LSB +: 2];
          next_st.channel_output_enable = wdata[TMR16_OE_LSB +: 3];
        end
        TMR16_DIR_ADDR: next_st.dir_down = wdata[0];
        TMR16_COUNT_ADDR: next_st.count = wdata[15:0];
        TMR16_PERIOD_ADDR: next_st.period = wdata[15:0];
        TMR16_PERIOD_BUFFER_ADDR: begin
          next_st.period_buffer = wdata[15:0];
          next_st.period_buffer_valid = 1'b1;
        end
        TMR16_FLAGS_ADDR: begin
          // Set wins over a clear landing in the same cycle
          for (int i = 0; i < TMR16_NCH; i++) begin
            if (wdata[i] && !(tick && match[i])) begin
              next_st.match_flag[i] = 1'b0;
            end
          end
        end
        default: begin
          for (int i = 0; i < TMR16_NCH; i++) begin
            if (16'(addr) == chan_addr(TMR16_CMP_ADDR, i)) begin
              next_st.compare_n[i] = wdata[15:0];
            end
            if (16'(addr) == chan_addr(TMR16_CMPBUF_ADDR, i)) begin
              next_st.compare_n_buffer[i] = wdata[15:0];
              next_st.compare_buffer_valid[i] = 1'b1;
            end
          end
        end
      endcase
    end

    // ------------------------------------------------------------
    // Register reads, unmapped read zero
    // ------------------------------------------------------------
    if (rd) begin
      case (addr)
        TMR16_CTRL_ADDR: next_st.rdata = {26'h0, st.transfer_lock, st.event_count_enable,
          st.clock_divider_select, st.enable};
        TMR16_WAVE_ADDR: next_st.rdata = {25'h0, st.channel_output_enable, 2'h0,
          st.waveform_mode_select};
        TMR16_DIR_ADDR: next_st.rdata = {31'h0, st.dir_down};
        TMR16_BUFST_ADDR: next_st.rdata = {28'h0, st.compare_buffer_valid,
          st.period_buffer_valid};
        TMR16_COUNT_ADDR: next_st.rdata = {16'h0, st.count};
        TMR16_PERIOD_ADDR: next_st.rdata = {16'h0, st.period};
        TMR16_PERIOD_BUFFER_ADDR: next_st.rdata = {16'h0, st.period_buffer};
        TMR16_FLAGS_ADDR: next_st.rdata = {29'h0, st.match_flag};
        default: begin
          for (int i = 0; i < TMR16_NCH; i++) begin
            if (16'(addr) == chan_addr(TMR16_CMP_ADDR, i)) begin
              next_st.rdata = {16'h0, st.compare_n[i]};
            end
            if (16'(addr) == chan_addr(TMR16_CMPBUF_ADDR, i)) begin
              next_st.rdata = {16'h0, st.compare_n_buffer[i]};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.period <= TMR16_PERIOD_RST;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  logic wave_active;
  assign wave_active = (mode == TMR16_FREQ) || (mode == TMR16_SSPWM);
  assign wave_drive_en = wave_active ? st.channel_output_enable : 3'h0;
  assign waveform_out_n = st.wave & wave_drive_en;
  assign rdata = st.rdata;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_count_write: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr && addr == TMR16_COUNT_ADDR |=> st.count == $past(wdata[15:0]))
    else $error("count write not immediate");
  chk_up_wrap: assert property (@(posedge ref_clk) disable iff (!nrst)
    tick && !st.dir_down && mode == TMR16_NORMAL && at_peak && !wr |=> st.count == 16'h0000)
    else $error("no wrap at peak");
  chk_down_reload: assert property (@(posedge ref_clk) disable iff (!nrst)
    tick && st.dir_down && mode == TMR16_NORMAL && at_floor && !wr
    |=> st.count == $past(st.period))
    else $error("no reload at floor");
  chk_up_step: assert property (@(posedge ref_clk) disable iff (!nrst)
    tick && !st.dir_down && !at_peak && !wr |=> st.count == $past(st.count) + 16'h0001)
    else $error("bad up step");
  chk_idle_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    !st.enable && !wr |=> $stable(st.count))
    else $error("count moved while disabled");
  chk_buf_valid: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr && addr == TMR16_PERIOD_BUFFER_ADDR |=> st.period_buffer_valid)
    else $error("buffer valid not set");
  chk_lock_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    st.transfer_lock && !wr |=> $stable(st.compare_n))
    else $error("compare changed while locked");
  chk_match_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
    tick && match[0] |=> st.match_flag[0])
    else $error("match flag missing");
  chk_pin_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
    !st.channel_output_enable[0] |-> !waveform_out_n[0])
    else $error("pin driven while disabled");
  chk_freq_toggle: assert property (@(posedge ref_clk) disable iff (!nrst)
    tick && mode == TMR16_FREQ && match[1] |=> st.wave[1] != $past(st.wave[1]))
    else $error("no toggle on match");
  chk_period_write: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr && addr == TMR16_PERIOD_ADDR |=> st.period == $past(wdata[15:0]))
    else $error("period write not immediate");
  chk_cmp_write: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr && addr == TMR16_CMP_ADDR |=> st.compare_n[0] == $past(wdata[15:0]))
    else $error("direct compare write lost");
  chk_dir_write: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr && addr == TMR16_DIR_ADDR |=> st.dir_down == $past(wdata[0]))
    else $error("direction write lost");
  chk_down_step: assert property (@(posedge ref_clk) disable iff (!nrst)
    tick && st.dir_down && mode == TMR16_NORMAL && !at_floor && !wr
    |=> st.count == $past(st.count) - 16'h0001)
    else $error("bad down step");
  chk_event_only: assert property (@(posedge ref_clk) disable iff (!nrst)
    st.event_count_enable && !(st.evt_sync[1] && !st.evt_sync[2]) && !wr
    |=> $stable(st.count))
    else $error("count moved without event");
  chk_period_buffer_copy: assert property (@(posedge ref_clk) disable iff (!nrst)
    update && !st.transfer_lock && st.period_buffer_valid && !wr
    |=> st.period == $past(st.period_buffer) && !st.period_buffer_valid)
    else $error("period buffer not copied");
  chk_cmpbuf_copy: assert property (@(posedge ref_clk) disable iff (!nrst)
    update && !st.transfer_lock && st.compare_buffer_valid[1] && !wr
    |=> st.compare_n[1] == $past(st.compare_n_buffer[1]))
    else $error("compare buffer not copied");
  chk_no_early_copy: assert property (@(posedge ref_clk) disable iff (!nrst)
    !update && !wr |=> $stable(st.period))
    else $error("period changed off update");
  chk_freq_top: assert property (@(posedge ref_clk) disable iff (!nrst)
    tick && mode == TMR16_FREQ && st.count == st.compare_n[0] && !wr
    |=> st.count == 16'h0000)
    else $error("compare zero did not end period");
  chk_pwm_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    tick && mode == TMR16_SSPWM && at_floor && !match[0] |=> st.wave[0])
    else $error("output not set at floor");
  chk_pwm_low: assert property (@(posedge ref_clk) disable iff (!nrst)
    tick && mode == TMR16_SSPWM && match[1] |=> !st.wave[1])
    else $error("output not cleared on match");
  chk_div_tick: assert property (@(posedge ref_clk) disable iff (!nrst)
    tick && !st.event_count_enable && st.clock_divider_select != 3'h0 && !wr
    |=> !tick)
    else $error("divided tick longer than one cycle");

  cov_wrap: cover property (@(posedge ref_clk) tick && at_peak && !st.dir_down);
  cov_update: cover property (@(posedge ref_clk) update && st.period_buffer_valid);
  cov_pwm: cover property (@(posedge ref_clk) mode == TMR16_SSPWM && $rose(st.wave[0]));
  cov_event: cover property (@(posedge ref_clk) tick && st.event_count_enable);
  cov_flag: cover property (@(posedge ref_clk) tick && match[2]);

endmodule

// ### test/tmr16_pin_load.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Pin loads on the waveform outputs
// ------------------------------------------------------------
module tmr16_pin_load (
  input wire logic ref_clk,
  input wire logic clr,
  input wire logic [2:0] waveform_out_n,
  input wire logic [2:0] wave_drive_en,
  output logic [2:0] pin,
  output logic [2:0][15:0] tog_cnt,
  output logic [2:0][15:0] high_cnt
);
  logic [2:0] prev;
  // A pin the timer does not override sits at its pull-down level
  assign pin = waveform_out_n & wave_drive_en;
  always_ff @(posedge ref_clk) begin
    prev <= pin;
    for (int i = 0; i < 3; i++) begin
      if (clr) begin
        tog_cnt[i] <= 16'h0000;
        high_cnt[i] <= 16'h0000;
      end else begin
        tog_cnt[i] <= tog_cnt[i] + 16'(pin[i] ^ prev[i]);
        high_cnt[i] <= high_cnt[i] + 16'(pin[i]);
      end
    end
  end
endmodule

// ### test/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import tmr16_pkg::*;
;
  logic ref_clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, event_in = 1'b0, clr = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata;
  logic [2:0] waveform_out_n, wave_drive_en, pin;
  logic [2:0][15:0] tog_cnt, high_cnt;
  int miscompares = 0, compares = 0;

  tmr16_core dut_u (.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .event_in(event_in), .waveform_out_n(waveform_out_n),
    .wave_drive_en(wave_drive_en));
  tmr16_pin_load load_u (.ref_clk(ref_clk), .clr(clr), .waveform_out_n(waveform_out_n),
    .wave_drive_en(wave_drive_en), .pin(pin), .tog_cnt(tog_cnt), .high_cnt(high_cnt));

  always #2 ref_clk = ~ref_clk;

  // ------------------------------------------------------------
  // Bus, event and pin helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= {16'h0000, d};
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [5:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, {16'h0000, e});
  endtask
  // Long gaps so the synchroniser sees each rising edge once
  task automatic ev(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      event_in <= 1'b1;
      repeat (2) @(posedge ref_clk);
      event_in <= 1'b0;
      repeat (5) @(posedge ref_clk);
    end
  endtask
  task automatic watch(input int n);
    repeat (10) @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic report_and_stop;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_count;
    rd_chk(TMR16_PERIOD_ADDR, 16'hffff);
    rd_chk(6'h38, 16'h0000);
    wr_reg(TMR16_WAVE_ADDR, 16'h0070);
    wr_reg(TMR16_PERIOD_ADDR, 16'h0003);
    wr_reg(TMR16_CTRL_ADDR, 16'h0011);
    #1;
    chk({29'h0, wave_drive_en}, 32'h0);
    rd_chk(TMR16_PERIOD_ADDR, 16'h0003);
    wr_reg(TMR16_COUNT_ADDR, 16'h0002);
    rd_chk(TMR16_COUNT_ADDR, 16'h0002);
    ev(1);
    rd_chk(TMR16_COUNT_ADDR, 16'h0003);
    ev(1);
    rd_chk(TMR16_COUNT_ADDR, 16'h0000);
    wr_reg(TMR16_COUNT_ADDR, 16'h0005);
    ev(1);
    rd_chk(TMR16_COUNT_ADDR, 16'h0006);
    wr_reg(TMR16_DIR_ADDR, 16'h0001);
    wr_reg(TMR16_COUNT_ADDR, 16'h0001);
    ev(1);
    rd_chk(TMR16_COUNT_ADDR, 16'h0000);
    ev(1);
    rd_chk(TMR16_COUNT_ADDR, 16'h0003);
  endtask
  task automatic t_buffer;
    wr_reg(TMR16_PERIOD_BUFFER_ADDR, 16'h0007);
    wr_reg(TMR16_CMPBUF_ADDR + 6'h04, 16'h0005);
    wr_reg(TMR16_CMP_ADDR + 6'h08, 16'h000a);
    rd_chk(TMR16_BUFST_ADDR, 16'h0005);
    rd_chk(TMR16_CMP_ADDR + 6'h08, 16'h000a);
    ev(1);
    rd_chk(TMR16_PERIOD_ADDR, 16'h0003);
    rd_chk(TMR16_CMP_ADDR + 6'h04, 16'h0000);
    ev(3);
    rd_chk(TMR16_PERIOD_ADDR, 16'h0007);
    rd_chk(TMR16_CMP_ADDR + 6'h04, 16'h0005);
    rd_chk(TMR16_BUFST_ADDR, 16'h0000);
    wr_reg(TMR16_CTRL_ADDR, 16'h0031);
    wr_reg(TMR16_PERIOD_BUFFER_ADDR, 16'h0009);
    wr_reg(TMR16_COUNT_ADDR, 16'h0001);
    ev(2);
    rd_chk(TMR16_PERIOD_ADDR, 16'h0007);
    rd_chk(TMR16_BUFST_ADDR, 16'h0001);
    wr_reg(TMR16_CTRL_ADDR, 16'h0011);
    wr_reg(TMR16_COUNT_ADDR, 16'h0001);
    ev(2);
    rd_chk(TMR16_PERIOD_ADDR, 16'h0009);
  endtask
  task automatic t_flags;
    wr_reg(TMR16_DIR_ADDR, 16'h0000);
    wr_reg(TMR16_PERIOD_ADDR, 16'h0020);
    wr_reg(TMR16_COUNT_ADDR, 16'h0009);
    wr_reg(TMR16_FLAGS_ADDR, 16'h0007);
    ev(1);
    rd_chk(TMR16_FLAGS_ADDR, 16'h0000);
    ev(1);
    rd_chk(TMR16_FLAGS_ADDR, 16'h0004);
  endtask
  task automatic t_freq;
    wr_reg(TMR16_CMP_ADDR, 16'h0003);
    wr_reg(TMR16_CMP_ADDR + 6'h04, 16'h0001);
    wr_reg(TMR16_COUNT_ADDR, 16'h0000);
    wr_reg(TMR16_WAVE_ADDR, 16'h0031);
    wr_reg(TMR16_CTRL_ADDR, 16'h0001);
    watch(16);
    chk({29'h0, wave_drive_en}, 32'h3);
    chk({16'h0, tog_cnt[0]}, 32'h4);
    chk({16'h0, tog_cnt[1]}, 32'h4);
    chk({16'h0, tog_cnt[2]}, 32'h0);
    wr_reg(TMR16_CTRL_ADDR, 16'h0000);
    wr_reg(TMR16_CMP_ADDR, 16'h0000);
    wr_reg(TMR16_COUNT_ADDR, 16'h0000);
    wr_reg(TMR16_CTRL_ADDR, 16'h0001);
    watch(16);
    chk({16'h0, tog_cnt[0]}, 32'h10);
    // Divide by four: one toggle every fourth clock
    wr_reg(TMR16_CTRL_ADDR, 16'h0005);
    watch(16);
    chk({16'h0, tog_cnt[0]}, 32'h4);
  endtask
  task automatic t_pwm;
    wr_reg(TMR16_CTRL_ADDR, 16'h0000);
    wr_reg(TMR16_PERIOD_ADDR, 16'h0007);
    wr_reg(TMR16_CMP_ADDR, 16'h0003);
    wr_reg(TMR16_CMP_ADDR + 6'h04, 16'h0000);
    wr_reg(TMR16_CMP_ADDR + 6'h08, 16'h0008);
    wr_reg(TMR16_COUNT_ADDR, 16'h0000);
    wr_reg(TMR16_WAVE_ADDR, 16'h0072);
    wr_reg(TMR16_CTRL_ADDR, 16'h0001);
    watch(16);
    chk({16'h0, tog_cnt[0]}, 32'h4);
    chk({16'h0, high_cnt[0]}, 32'h6);
    chk({16'h0, high_cnt[1]}, 32'h0);
    chk({16'h0, high_cnt[2]}, 32'h10);
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    t_count();
    t_buffer();
    t_flags();
    t_freq();
    t_pwm();
    report_and_stop();
  end
  initial begin
    repeat (50000) @(posedge ref_clk);
    miscompares++;
    report_and_stop();
  end
endmodule
